// ---- swgc_control.sv ----
`timescale 1ns/1ps
//Operation
// - While reset_hold (bit 2) is set, all switch logic except the slave SMBus interface stays in quasi-reset.
// - During the hold state, register initialization writes from the slave SMBus interface are accepted.
// - Clearing reset_hold lets the switch leave quasi-reset and start normal operation.
// - Once the fundamental reset sequence has completed, writing reset_hold has no effect on operation.
// - On the first cycle after reset is released, reset_hold is loaded from the reset-hold strap of the boot configuration vector.
// - While register_write_unlock (bit 3) is set, lock-protected fields take written values.
// - While register_write_unlock is clear, lock-protected fields are read-only and ignore writes.
// - register_write_unlock resets to 0 but is set during the reset sequence so the EEPROM loader can write.
// - power_budget_unlock (bit 4), itself lock-protected, makes all power budget data registers writable.
// - With device_number_check_mode 0, ID-routed TLPs to a link bus with nonzero device number are blocked.
// - With device_number_check_mode 1, only such configuration requests are blocked.
// - With device_number_check_mode 2, all TLPs are delivered whatever their device number.
module swgc_control (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // register access
  input  swgc_pkg::swgc_reg_req_t      regReq,
  output logic [31:0]                  rdData_r,
  output logic                         rdValid_r,
  // boot configuration and loader
  input  wire logic                    bootResetHold,
  input  wire logic                    eepromLoadDone,
  // control state to the switch
  output swgc_pkg::swgc_ctrl_t         ctrl_r,
  output swgc_pkg::swgc_seq_state_t    seqState,
  output logic                         coreQuasiReset,
  // downstream device number filter
  input  swgc_pkg::swgc_tlp_info_t     tlpIn,
  output logic                         tlpVerdictValid,
  output logic                         tlpBlock
);
  import swgc_pkg::*;

  swgc_ctrl_t  ctrl_nxt;
  logic [31:0] rdData_nxt;
  logic        rdValid_nxt;
  logic        hitCtrl;
  logic        wrAllowed;
  logic        capturing;

  swgc_reset_seq u_seq (
    .clock        (clock),
    .reset        (reset),
    .holdBit      (ctrl_r.resetHold),
    .loadDone     (eepromLoadDone),
    .state_r      (seqState),
    .quasiReset_r (coreQuasiReset)
  );

  swgc_dev_filter u_filter (
    .clock        (clock),
    .reset        (reset),
    .mode         (ctrl_r.dncMode),
    .quiesce      (coreQuasiReset),
    .tlp          (tlpIn),
    .blockValid_r (tlpVerdictValid),
    .block_r      (tlpBlock)
  );

  // reserved bits stay zero in the read image
  function automatic logic [31:0] packCtrl(swgc_ctrl_t c);
    logic [31:0] w;
    w                              = 32'h0000_0000;
    w[SWGC_HOLD_BIT]               = c.resetHold;
    w[SWGC_UNLOCK_BIT]             = c.writeUnlock;
    w[SWGC_PWRUL_BIT]              = c.powerBudgetUnlock;
    w[SWGC_DNC_HI:SWGC_DNC_LO]     = c.dncMode;
    packCtrl                       = w;
  endfunction

  always_comb begin
    hitCtrl   = (regReq.addr == SWGC_CTRL_OFFSET);
    capturing = (seqState == SWGC_SEQ_CAPTURE);
    // core side is quiet in quasi-reset, so only the SMBus slave gets through
    wrAllowed = regReq.wrEn && hitCtrl && (regReq.fromSmbus || !coreQuasiReset);
    ctrl_nxt  = ctrl_r;
    if (capturing) begin
      ctrl_nxt.resetHold   = bootResetHold;
      ctrl_nxt.writeUnlock = 1'b1;
    end else if (wrAllowed) begin
      if (regReq.byteEn[SWGC_BYTE0]) begin
        ctrl_nxt.resetHold   = regReq.wrData[SWGC_HOLD_BIT];
        ctrl_nxt.writeUnlock = regReq.wrData[SWGC_UNLOCK_BIT];
        if (ctrl_r.writeUnlock) begin
          ctrl_nxt.powerBudgetUnlock = regReq.wrData[SWGC_PWRUL_BIT];
        end
      end
      if (regReq.byteEn[SWGC_BYTE1]) begin
        ctrl_nxt.dncMode = swgc_dnc_mode_t'(regReq.wrData[SWGC_DNC_HI:SWGC_DNC_LO]);
      end
    end
  end

  always_comb begin
    rdValid_nxt = regReq.rdEn;
    // unmapped offsets answer zero
    rdData_nxt  = (regReq.rdEn && hitCtrl) ? packCtrl(ctrl_r) : 32'h0000_0000;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r.resetHold         <= SWGC_HOLD_RST;
      ctrl_r.writeUnlock       <= SWGC_UNLOCK_RST;
      ctrl_r.powerBudgetUnlock <= SWGC_PWRUL_RST;
      ctrl_r.dncMode           <= swgc_dnc_mode_t'(SWGC_DNC_RST);
      rdData_r                 <= 32'h0000_0000;
      rdValid_r                <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic ctrlWrite;
  logic nonZeroTarget;
  assign ctrlWrite     = regReq.wrEn && hitCtrl && !capturing;
  assign nonZeroTarget = tlpIn.valid && tlpIn.idRouted && tlpIn.onLinkBus && (tlpIn.devNum != '0);

  AST_STRAP_LOADED:
    assert property (capturing |=> ctrl_r.resetHold == $past(bootResetHold))
      else $error("reset_hold not loaded from boot strap");

  AST_UNLOCK_IN_SEQ:
    assert property (capturing |=> ctrl_r.writeUnlock && seqState == SWGC_SEQ_LOAD)
      else $error("write unlock not set during reset sequence");

  AST_HOLD_QUIET:
    assert property ((seqState == SWGC_SEQ_HOLD && ctrl_r.resetHold)
                     |=> coreQuasiReset && !tlpVerdictValid)
      else $error("switch logic active while reset_hold set");

  AST_LEAVE_HOLD:
    assert property ((seqState == SWGC_SEQ_HOLD && !ctrl_r.resetHold)
                     |=> !coreQuasiReset && seqState == SWGC_SEQ_RUN)
      else $error("quasi-reset not left after reset_hold cleared");

  AST_RUN_STICKS:
    assert property (seqState == SWGC_SEQ_RUN |=> !coreQuasiReset [*3])
      else $error("reset_hold write affected operation after sequence");

  AST_SMBUS_INIT:
    assert property ((coreQuasiReset && ctrlWrite && regReq.fromSmbus && regReq.byteEn[SWGC_BYTE1])
                     |=> ctrl_r.dncMode == $past(regReq.wrData[SWGC_DNC_HI:SWGC_DNC_LO]))
      else $error("SMBus write not accepted in hold state");

  AST_LOCKED_WRITE:
    assert property ((ctrlWrite && regReq.byteEn[SWGC_BYTE0] && ctrl_r.writeUnlock
                      && (regReq.fromSmbus || !coreQuasiReset))
                     |=> ctrl_r.powerBudgetUnlock == $past(regReq.wrData[SWGC_PWRUL_BIT]))
      else $error("lock-protected field ignored write while unlocked");

  AST_LOCKED_IGNORE:
    assert property ((!ctrl_r.writeUnlock && !capturing) |=> $stable(ctrl_r.powerBudgetUnlock))
      else $error("lock-protected field changed while locked");

  AST_RSVD_ZERO:
    assert property (rdValid_r |-> (rdData_r[1:0] == 2'h0 && rdData_r[8:5] == 4'h0
                                    && rdData_r[31:11] == 21'h0))
      else $error("reserved bits read nonzero");

  AST_READ_IMAGE:
    assert property ((regReq.rdEn && hitCtrl) |=> rdValid_r
                     && rdData_r[SWGC_PWRUL_BIT] == $past(ctrl_r.powerBudgetUnlock))
      else $error("power_budget_unlock read back wrong");

  AST_BLOCK_ALL:
    assert property ((!coreQuasiReset && ctrl_r.dncMode == SWGC_DNC_ALL && nonZeroTarget)
                     |=> tlpVerdictValid && tlpBlock)
      else $error("mode 0 did not block nonzero device number");

  AST_BLOCK_CFG:
    assert property ((!coreQuasiReset && ctrl_r.dncMode == SWGC_DNC_CFG && nonZeroTarget)
                     |=> tlpVerdictValid && (tlpBlock == $past(tlpIn.isConfig)))
      else $error("mode 1 filtered the wrong packets");

  AST_BLOCK_NONE:
    assert property ((ctrl_r.dncMode == SWGC_DNC_NONE && tlpIn.valid) |=> !tlpBlock)
      else $error("mode 2 blocked a packet");

  AST_CAPTURE_ONCE:
    assert property (seqState == SWGC_SEQ_CAPTURE |=> seqState == SWGC_SEQ_LOAD)
      else $error("capture state lasted more than one cycle");

  AST_CAPTURE_QUIET:
    assert property (capturing |=> coreQuasiReset)
      else $error("switch logic active right after strap capture");

  AST_LOAD_WAITS:
    assert property ((seqState == SWGC_SEQ_LOAD && !eepromLoadDone)
                     |=> seqState == SWGC_SEQ_LOAD && coreQuasiReset)
      else $error("load phase left before the loader finished");

  AST_LOAD_ENDS:
    assert property ((seqState == SWGC_SEQ_LOAD && eepromLoadDone)
                     |=> seqState == SWGC_SEQ_HOLD && coreQuasiReset)
      else $error("load phase did not move to hold");

  AST_HOLD_STAYS:
    assert property ((seqState == SWGC_SEQ_HOLD && ctrl_r.resetHold)
                     |=> seqState == SWGC_SEQ_HOLD)
      else $error("hold state left while reset_hold set");

  AST_RUN_FOREVER:
    assert property (seqState == SWGC_SEQ_RUN |=> seqState == SWGC_SEQ_RUN)
      else $error("run state left without a reset");

  AST_QUIET_NO_VERDICT:
    assert property (coreQuasiReset |=> !tlpVerdictValid && !tlpBlock)
      else $error("verdict produced in quasi-reset");

  AST_VERDICT_FOLLOWS:
    assert property ((!coreQuasiReset && tlpIn.valid) |=> tlpVerdictValid)
      else $error("no verdict for a packet in normal operation");

  AST_VERDICT_PULSE:
    assert property (!tlpIn.valid |=> !tlpVerdictValid)
      else $error("verdict without a packet");

  AST_BLOCK_QUALIFIED:
    assert property (tlpBlock |-> tlpVerdictValid)
      else $error("block raised without a verdict");

  AST_OUT_OF_SCOPE_PASS:
    assert property ((tlpIn.valid && !nonZeroTarget) |=> !tlpBlock)
      else $error("packet outside the filter scope was blocked");

  AST_CFG_NONCFG_PASS:
    assert property ((ctrl_r.dncMode == SWGC_DNC_CFG && tlpIn.valid && !tlpIn.isConfig) |=> !tlpBlock)
      else $error("mode 1 blocked a packet that is not a configuration request");

  AST_CORE_WRITE_DROP:
    assert property ((ctrlWrite && !regReq.fromSmbus && coreQuasiReset) |=> $stable(ctrl_r))
      else $error("core-side write landed in quasi-reset");

  AST_SMBUS_HOLD_WRITE:
    assert property ((seqState == SWGC_SEQ_HOLD && ctrlWrite && regReq.fromSmbus
                      && regReq.byteEn[SWGC_BYTE0])
                     |=> ctrl_r.writeUnlock == $past(regReq.wrData[SWGC_UNLOCK_BIT]))
      else $error("SMBus write refused in hold state");

  AST_OFFSET_DROP:
    assert property ((regReq.wrEn && !hitCtrl && !capturing) |=> $stable(ctrl_r))
      else $error("write to another offset changed the control register");

  AST_CTRL_HELD:
    assert property ((!ctrlWrite && !capturing) |=> $stable(ctrl_r))
      else $error("control register changed without a write");

  AST_BYTE0_MASKED:
    assert property ((ctrlWrite && !regReq.byteEn[SWGC_BYTE0])
                     |=> $stable(ctrl_r.resetHold) && $stable(ctrl_r.writeUnlock)
                         && $stable(ctrl_r.powerBudgetUnlock))
      else $error("low byte fields changed without their byte enable");

  AST_PLAIN_FIELDS:
    assert property ((ctrlWrite && regReq.byteEn[SWGC_BYTE0] && (regReq.fromSmbus || !coreQuasiReset))
                     |=> ctrl_r.writeUnlock == $past(regReq.wrData[SWGC_UNLOCK_BIT])
                         && ctrl_r.resetHold == $past(regReq.wrData[SWGC_HOLD_BIT]))
      else $error("plain fields of the low byte ignored a write");

  AST_BYTE1_MASKED:
    assert property ((ctrlWrite && !regReq.byteEn[SWGC_BYTE1]) |=> $stable(ctrl_r.dncMode))
      else $error("check mode changed without its byte enable");

  AST_READ_PULSE:
    assert property (regReq.rdEn |=> rdValid_r)
      else $error("read not answered in the next cycle");

  AST_READ_IDLE:
    assert property (!regReq.rdEn |=> !rdValid_r && rdData_r == 32'h0000_0000)
      else $error("read answer without a request");

  AST_UNMAPPED_ZERO:
    assert property ((regReq.rdEn && !hitCtrl) |=> rdData_r == 32'h0000_0000)
      else $error("unmapped offset read nonzero");

  AST_READ_FIELDS:
    assert property ((regReq.rdEn && hitCtrl)
                     |=> rdData_r[SWGC_HOLD_BIT] == $past(ctrl_r.resetHold)
                         && rdData_r[SWGC_UNLOCK_BIT] == $past(ctrl_r.writeUnlock)
                         && rdData_r[SWGC_DNC_HI:SWGC_DNC_LO] == $past(ctrl_r.dncMode))
      else $error("read image does not match the control state");

  COV_HOLD_RELEASE:
    cover property (seqState == SWGC_SEQ_HOLD ##1 seqState == SWGC_SEQ_RUN);

  COV_SMBUS_INIT:
    cover property (coreQuasiReset && ctrlWrite && regReq.fromSmbus);

  COV_LOCKED_TRY:
    cover property (ctrlWrite && !ctrl_r.writeUnlock && regReq.byteEn[SWGC_BYTE0]);

  COV_CFG_BLOCK:
    cover property (ctrl_r.dncMode == SWGC_DNC_CFG ##1 tlpBlock);

  COV_NONE_PASS:
    cover property ((ctrl_r.dncMode == SWGC_DNC_NONE && nonZeroTarget) ##1 (tlpVerdictValid && !tlpBlock));

endmodule // swgc_control

// ---- swgc_pkg.sv ----
package swgc_pkg;

  // register map
  localparam int          SWGC_ADDR_W       = 12;
  localparam int          SWGC_DATA_W       = 32;
  localparam int          SWGC_BE_W         = 4;
  localparam int          SWGC_DEVNUM_W     = 5;
  localparam logic [11:0] SWGC_CTRL_OFFSET  = 12'h000;

  // field positions inside switch_control
  localparam int SWGC_HOLD_BIT   = 2;
  localparam int SWGC_UNLOCK_BIT = 3;
  localparam int SWGC_PWRUL_BIT  = 4;
  localparam int SWGC_DNC_LO     = 9;
  localparam int SWGC_DNC_HI     = 10;
  localparam int SWGC_BYTE0      = 0;
  localparam int SWGC_BYTE1      = 1;

  // reset values; reset_hold is replaced by the strap right after release
  localparam logic       SWGC_HOLD_RST   = 1'b0;
  localparam logic       SWGC_UNLOCK_RST = 1'b0;
  localparam logic       SWGC_PWRUL_RST  = 1'b0;
  localparam logic [1:0] SWGC_DNC_RST    = 2'h0;

  typedef enum logic [1:0] {
    SWGC_DNC_ALL  = 2'h0,
    SWGC_DNC_CFG  = 2'h1,
    SWGC_DNC_NONE = 2'h2,
    SWGC_DNC_RSVD = 2'h3
  } swgc_dnc_mode_t;

  // gray along capture -> load -> hold -> run
  typedef enum logic [1:0] {
    SWGC_SEQ_CAPTURE = 2'b00,
    SWGC_SEQ_LOAD    = 2'b01,
    SWGC_SEQ_HOLD    = 2'b11,
    SWGC_SEQ_RUN     = 2'b10
  } swgc_seq_state_t;

  typedef struct packed {
    logic                     wrEn;
    logic                     rdEn;
    logic                     fromSmbus;
    logic [SWGC_ADDR_W-1:0]   addr;
    logic [SWGC_DATA_W-1:0]   wrData;
    logic [SWGC_BE_W-1:0]     byteEn;
  } swgc_reg_req_t;

  typedef struct packed {
    logic                     valid;
    logic                     idRouted;
    logic                     isConfig;
    logic                     onLinkBus;
    logic [SWGC_DEVNUM_W-1:0] devNum;
  } swgc_tlp_info_t;

  typedef struct packed {
    logic           resetHold;
    logic           writeUnlock;
    logic           powerBudgetUnlock;
    swgc_dnc_mode_t dncMode;
  } swgc_ctrl_t;

endpackage

// ---- swgc_reset_seq.sv ----
`timescale 1ns/1ps
module swgc_reset_seq (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // sequence inputs
  input  wire logic                   holdBit,
  input  wire logic                   loadDone,
  // sequence state
  output swgc_pkg::swgc_seq_state_t   state_r,
  output logic                        quasiReset_r
);
  import swgc_pkg::*;

  swgc_seq_state_t state_nxt;
  logic            quasiReset_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SWGC_SEQ_CAPTURE: state_nxt = SWGC_SEQ_LOAD;
      SWGC_SEQ_LOAD:    if (loadDone) state_nxt = SWGC_SEQ_HOLD;
      SWGC_SEQ_HOLD:    if (!holdBit) state_nxt = SWGC_SEQ_RUN;
      SWGC_SEQ_RUN:     state_nxt = SWGC_SEQ_RUN;  // bit no longer matters
      default:          state_nxt = SWGC_SEQ_CAPTURE;
    endcase
    quasiReset_nxt = (state_nxt != SWGC_SEQ_RUN);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r      <= SWGC_SEQ_CAPTURE;
      quasiReset_r <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      quasiReset_r <= quasiReset_nxt;
    end
  end

endmodule // swgc_reset_seq

// ---- swgc_dev_filter.sv ----
`timescale 1ns/1ps
module swgc_dev_filter (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // control
  input  swgc_pkg::swgc_dnc_mode_t mode,
  input  wire logic                quiesce,
  // packet descriptor and verdict
  input  swgc_pkg::swgc_tlp_info_t tlp,
  output logic                     blockValid_r,
  output logic                     block_r
);
  import swgc_pkg::*;

  logic blockValid_nxt;
  logic block_nxt;

  function automatic logic mustBlock(swgc_dnc_mode_t m, swgc_tlp_info_t t);
    logic nonZero;
    nonZero = t.idRouted && t.onLinkBus && (t.devNum != '0);
    case (m)
      SWGC_DNC_ALL:  mustBlock = nonZero;
      SWGC_DNC_CFG:  mustBlock = nonZero && t.isConfig;
      SWGC_DNC_NONE: mustBlock = 1'b0;
      // reserved code: fail safe by filtering as strictly as possible
      default:       mustBlock = nonZero;
    endcase
  endfunction

  always_comb begin
    blockValid_nxt = tlp.valid && !quiesce;
    block_nxt      = blockValid_nxt && mustBlock(mode, tlp);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      blockValid_r <= 1'b0;
      block_r      <= 1'b0;
    end else begin
      blockValid_r <= blockValid_nxt;
      block_r      <= block_nxt;
    end
  end

endmodule // swgc_dev_filter

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import swgc_pkg::*;
  // stimulus and observed signals
  logic           clock;
  logic           reset;
  swgc_reg_req_t  regReq;
  logic [31:0]    rdData_r;
  logic           rdValid_r;
  logic           bootResetHold;
  logic           eepromLoadDone;
  swgc_ctrl_t     ctrl_r;
  swgc_seq_state_t seqState;
  logic           coreQuasiReset;
  swgc_tlp_info_t tlpIn;
  logic           tlpVerdictValid;
  logic           tlpBlock;
  int             failures;
  int             compares;
  logic           expBlock;

  swgc_control u_swgc_control (
    .clock(clock), .reset(reset), .regReq(regReq), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
    .bootResetHold(bootResetHold), .eepromLoadDone(eepromLoadDone), .ctrl_r(ctrl_r),
    .seqState(seqState), .coreQuasiReset(coreQuasiReset), .tlpIn(tlpIn),
    .tlpVerdictValid(tlpVerdictValid), .tlpBlock(tlpBlock));

  always #2 clock = ~clock;

  // inputs move 1 ns after the edge, never on it
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  function automatic logic [31:0] img(input logic h, input logic u, input logic p, input logic [1:0] m);
    return {21'h0, m, 4'h0, p, u, h, 2'h0};
  endfunction

  task automatic wr(input logic sm, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, fromSmbus: sm, addr: a, wrData: d, byteEn: be};
    step();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, fromSmbus: 1'b0, addr: a, wrData: 32'h0, byteEn: 4'h0};
    step();
    chk({31'h0, rdValid_r}, 32'h1, "read answer");
    chk(rdData_r, exp, "read data");
  endtask

  task automatic tl(input logic i, input logic c, input logic l, input logic [4:0] d, input logic e);
    tlpIn = '{valid: 1'b1, idRouted: i, isConfig: c, onLinkBus: l, devNum: d};
    step();
    chk({31'h0, tlpVerdictValid}, 32'h1, "verdict strobe");
    chk({31'h0, tlpBlock}, {31'h0, e}, "verdict");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run is about 60 cycles, far inside the 5000-cycle limit
  initial begin
    #20000;
    failures++;
    final_report();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    regReq = '0;
    bootResetHold = 1'b1;
    eepromLoadDone = 1'b0;
    tlpIn = '0;
    failures = 0;
    compares = 0;
    repeat (6) step();
    chk({27'h0, ctrl_r}, 32'h0, "control in reset");
    chk({31'h0, coreQuasiReset}, 32'h1, "quiesced in reset");
    reset = 1'b0;
    step();
    chk({31'h0, ctrl_r.resetHold}, 32'h1, "strap capture");
    chk({31'h0, ctrl_r.writeUnlock}, 32'h1, "unlock during load");
    tlpIn = '{valid: 1'b1, idRouted: 1'b1, isConfig: 1'b0, onLinkBus: 1'b1, devNum: 5'h3};
    step();
    chk({31'h0, tlpVerdictValid}, 32'h0, "no verdict while quiesced");
    tlpIn = '0;
    wr(1'b0, 12'h000, 32'h0000_0400, 4'hf);
    rd(12'h000, img(1'b1, 1'b1, 1'b0, 2'h0));
    wr(1'b1, 12'h000, 32'hffff_fdff, 4'hf);
    rd(12'h000, img(1'b1, 1'b1, 1'b1, 2'h2));
    eepromLoadDone = 1'b1;
    wr(1'b1, 12'h000, 32'h0000_001c, 4'hf);
    eepromLoadDone = 1'b0;
    regReq = '0;
    step();
    chk({31'h0, coreQuasiReset}, 32'h1, "still held");
    // clearing the hold bit: run reached within a few cycles
    wr(1'b1, 12'h000, 32'h0000_0018, 4'h1);
    regReq = '0;
    for (int n = 0; n < 4 && coreQuasiReset !== 1'b0; n++) step();
    chk({31'h0, coreQuasiReset}, 32'h0, "normal operation");
    wr(1'b0, 12'h000, 32'h0000_001c, 4'h1);
    regReq = '0;
    repeat (3) step();
    chk({31'h0, coreQuasiReset}, 32'h0, "hold write after sequence");
    rd(12'h000, img(1'b1, 1'b1, 1'b1, 2'h0));
    wr(1'b0, 12'h000, 32'h0000_0014, 4'h1);
    wr(1'b0, 12'h000, 32'h0000_0004, 4'h1);
    rd(12'h000, img(1'b1, 1'b0, 1'b1, 2'h0));
    wr(1'b0, 12'h000, 32'h0000_000c, 4'h1);
    wr(1'b0, 12'h000, 32'h0000_000c, 4'h1);
    rd(12'h000, img(1'b1, 1'b1, 1'b0, 2'h0));
    wr(1'b0, 12'h004, 32'h0000_0600, 4'hf);
    rd(12'h004, 32'h0);
    // byte 1 only: low byte data must not disturb bits 4:2
    wr(1'b0, 12'h000, 32'h0000_0200, 4'h2);
    rd(12'h000, img(1'b1, 1'b1, 1'b0, 2'h1));
    for (int m = 0; m < 3; m++) begin
      wr(1'b0, 12'h000, 32'(m) << 9, 4'h2);
      regReq = '0;
      for (int k = 0; k < 5; k++) begin
        expBlock = (k < 2) && (m == 0 || (m == 1 && k == 1));
        case (k)
          0: tl(1'b1, 1'b0, 1'b1, 5'h03, expBlock);
          1: tl(1'b1, 1'b1, 1'b1, 5'h1f, expBlock);
          2: tl(1'b1, 1'b1, 1'b1, 5'h00, expBlock);
          3: tl(1'b1, 1'b1, 1'b0, 5'h03, expBlock);
          default: tl(1'b0, 1'b0, 1'b1, 5'h03, expBlock);
        endcase
      end
      tlpIn = '0;
      step();
    end
    // second reset with the strap low runs straight through
    reset = 1'b1;
    bootResetHold = 1'b0;
    step();
    chk({27'h0, ctrl_r}, 32'h0, "control in second reset");
    reset = 1'b0;
    step();
    chk({31'h0, ctrl_r.resetHold}, 32'h0, "low strap capture");
    eepromLoadDone = 1'b1;
    step();
    eepromLoadDone = 1'b0;
    step();
    chk({31'h0, coreQuasiReset}, 32'h0, "run without hold");
    final_report();
  end
endmodule // tb
